// >>> hw/gwd_map.svh
// Constant map of the selectable-period watchdog: timing, select codes,
// register offsets, field positions and reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef GWD_MAP_SVH
`define GWD_MAP_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
// Core clock period in ns (25 MHz)
`define GWD_CLK_PERIOD_NS 40
// Base tick time in ns (1 ms)
`define GWD_TICK_TIME_NS 1000000
// Cycles per 1 ms tick, rounded up
`define GWD_TICK_CYCLES ((`GWD_TICK_TIME_NS + `GWD_CLK_PERIOD_NS - 1) / `GWD_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Period select codes and timeouts in ms
// ----------------------------------------------------------------
`define GWD_SEL_1MS 3'h0
`define GWD_SEL_10MS 3'h1
`define GWD_SEL_30MS 3'h2
`define GWD_SEL_DISABLED 3'h3
`define GWD_SEL_100MS 3'h4
`define GWD_SEL_1S 3'h5
`define GWD_SEL_10S 3'h6
`define GWD_SEL_1MIN 3'h7
// 1 ms
`define GWD_PERIOD_1MS 16'h0001
// 10 ms
`define GWD_PERIOD_10MS 16'h000A
// 30 ms
`define GWD_PERIOD_30MS 16'h001E
// 100 ms
`define GWD_PERIOD_100MS 16'h0064
// 1 s
`define GWD_PERIOD_1S 16'h03E8
// 10 s
`define GWD_PERIOD_10S 16'h2710
// 1 minute
`define GWD_PERIOD_1MIN 16'hEA60

// ----------------------------------------------------------------
// Register bus
// ----------------------------------------------------------------
`define GWD_ADDR_W 8
`define GWD_DATA_W 32
`define GWD_OFF_STATUS 8'h00
`define GWD_OFF_MASK 8'h04
`define GWD_OFF_PULSE 8'h08
`define GWD_OFF_SELECT 8'h0C
`define GWD_OFF_COUNT 8'h10

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define GWD_EVT_W 2
`define GWD_EVT_TIMEOUT 0
`define GWD_EVT_KICK 1
`define GWD_SELRD_SEL_LSB 0
`define GWD_SELRD_STATE_LSB 4
`define GWD_CNT_W 16
`define GWD_STATUS_RST 2'h0
`define GWD_MASK_RST 2'h0
`define GWD_PULSE_RST 16'h0001

`endif

// >>> hw/gwd_pkg.sv
// Types shared by the watchdog design files.
// Assumes the constant map is on the include path.
`include "gwd_map.svh"

package gwd_pkg;

	// Watchdog sequencing, one-hot
	typedef enum logic [2:0] {
		GWD_IDLE = 3'b001,
		GWD_RUN = 3'b010,
		GWD_FIRE = 3'b100
	} gwd_state_t;

	// One register bus request
	typedef struct packed {
		logic [`GWD_ADDR_W-1:0] addr;
		logic [`GWD_DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} gwd_bus_req_t;

endpackage : gwd_pkg

// >>> hw/gwd_tick_div.sv
// Divider making the 1 ms enable pulse of the watchdog.
// Assumes one clock; clear restarts the phase so a period starts exactly.
`timescale 1ns/1ns
`include "gwd_map.svh"

module gwd_tick_div #(
	parameter int TICK_CYCLES = `GWD_TICK_CYCLES
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clear,
	output logic tick
);

	localparam int CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
	localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic tick_q;
	logic tick_d;

	always_comb begin
		cnt_d = cnt_q;
		tick_d = 1'b0;
		if (clear) begin
			cnt_d = '0;
		end else if (cnt_q == LAST) begin
			cnt_d = '0;
			tick_d = 1'b1;
		end else begin
			cnt_d = cnt_q + CW'(1);
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;

endmodule : gwd_tick_div

// >>> hw/gwd_top.sv
// Selectable-period watchdog driven by four hub output lines.
// Assumes the pins are asynchronous to core_clk and software also
// reaches a small register file over a plain strobe port.
//
// How it works
// - Expiry without a kick while enabled asserts the system reset output.
// - Timing starts when the select code leaves the disabled code.
// - Select codes map to 1ms,10ms,30ms,100ms,1s,10s and one minute.
// - Code 011 disables: no new reset (a running pulse still ends), count held idle; this is the default.
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "gwd_map.svh"

module gwd_top #(
	parameter int TICK_CYCLES = `GWD_TICK_CYCLES
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic hubGpioKickPin,
	input wire logic hubGpioSelHiPin,
	input wire logic hubGpioSelMidPin,
	input wire logic hubGpioSelLoPin,
	input wire gwd_pkg::gwd_bus_req_t busReq,
	output logic [`GWD_DATA_W-1:0] busRdata,
	output logic sysReset,
	output logic irq
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// period decode
	function automatic logic [`GWD_CNT_W-1:0] gwd_period_ms(input logic [2:0] sel);
		logic [`GWD_CNT_W-1:0] p;
		p = `GWD_PERIOD_1MS;
		case (sel)
			`GWD_SEL_1MS: p = `GWD_PERIOD_1MS;
			`GWD_SEL_10MS: p = `GWD_PERIOD_10MS;
			`GWD_SEL_30MS: p = `GWD_PERIOD_30MS;
			`GWD_SEL_100MS: p = `GWD_PERIOD_100MS;
			`GWD_SEL_1S: p = `GWD_PERIOD_1S;
			`GWD_SEL_10S: p = `GWD_PERIOD_10S;
			`GWD_SEL_1MIN: p = `GWD_PERIOD_1MIN;
			default: p = `GWD_PERIOD_1MS;
		endcase
		return p;
	endfunction : gwd_period_ms

	function automatic logic gwd_hit(input logic [`GWD_ADDR_W-1:0] addr, input logic [`GWD_ADDR_W-1:0] off);
		return addr == off;
	endfunction : gwd_hit

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [3:0] pinRaw;
	logic [3:0] pinMeta_q;
	logic [3:0] pinSync_q;
	logic kickPrev_q;
	logic [2:0] selPrev_q;
	logic watchdogKickLine;
	logic [2:0] periodSelect;
	logic kickEdge;
	logic selChange;

	assign pinRaw = {hubGpioKickPin, hubGpioSelHiPin, hubGpioSelMidPin, hubGpioSelLoPin};

	// Power-on reads as disabled so no reset fires before the pins settle
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pinMeta_q <= {1'b0, `GWD_SEL_DISABLED};
			pinSync_q <= {1'b0, `GWD_SEL_DISABLED};
			kickPrev_q <= 1'b0;
			selPrev_q <= `GWD_SEL_DISABLED;
		end else begin
			pinMeta_q <= pinRaw;
			pinSync_q <= pinMeta_q;
			kickPrev_q <= watchdogKickLine;
			selPrev_q <= periodSelect;
		end
	end

	assign watchdogKickLine = pinSync_q[3];
	assign periodSelect = pinSync_q[2:0];
	assign kickEdge = watchdogKickLine ^ kickPrev_q;
	assign selChange = periodSelect != selPrev_q;

	// ----------------------------------------------------------------
	// Tick divider
	// ----------------------------------------------------------------
	logic divClear;
	logic msTick;

	gwd_tick_div #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.core_clk(core_clk),
		.resetn(resetn),
		.clear(divClear),
		.tick(msTick)
	);

	// ----------------------------------------------------------------
	// Watchdog sequencing
	// ----------------------------------------------------------------
	gwd_pkg::gwd_state_t state_q;
	gwd_pkg::gwd_state_t state_d;
	logic [`GWD_CNT_W-1:0] msCnt_q;
	logic [`GWD_CNT_W-1:0] msCnt_d;
	logic [`GWD_CNT_W-1:0] pulseCnt_q;
	logic [`GWD_CNT_W-1:0] pulseCnt_d;
	logic [`GWD_CNT_W-1:0] periodMs;
	logic [`GWD_CNT_W-1:0] pulseLen_q;
	logic [`GWD_CNT_W-1:0] pulseLenEff;
	logic sysReset_q;
	logic sysReset_d;
	logic evtTimeout;
	logic selDisabled;

	assign periodMs = gwd_period_ms(periodSelect);
	assign selDisabled = periodSelect == `GWD_SEL_DISABLED;
	// Zero length is taken as one tick, which the >= end test would also give
	assign pulseLenEff = (pulseLen_q == '0) ? `GWD_PULSE_RST : pulseLen_q;

	always_comb begin
		state_d = state_q;
		msCnt_d = msCnt_q;
		pulseCnt_d = pulseCnt_q;
		divClear = 1'b0;
		evtTimeout = 1'b0;
		case (state_q)
			gwd_pkg::GWD_IDLE: begin
				msCnt_d = '0;
				divClear = 1'b1;
				if (!selDisabled) begin
					state_d = gwd_pkg::GWD_RUN;
				end
			end
			gwd_pkg::GWD_RUN: begin
				if (selDisabled) begin
					state_d = gwd_pkg::GWD_IDLE;
					msCnt_d = '0;
					divClear = 1'b1;
				end else if (kickEdge || selChange) begin
					msCnt_d = '0;
					divClear = 1'b1;
				end else if (msTick) begin
					if (msCnt_q == periodMs - `GWD_CNT_W'(1)) begin
						state_d = gwd_pkg::GWD_FIRE;
						pulseCnt_d = '0;
						msCnt_d = '0;
						divClear = 1'b1;
						evtTimeout = 1'b1;
					end else begin
						msCnt_d = msCnt_q + `GWD_CNT_W'(1);
					end
				end
			end
			gwd_pkg::GWD_FIRE: begin
				// Kicks are ignored while the reset pulse runs
				if (msTick) begin
					if (pulseCnt_q + `GWD_CNT_W'(1) >= pulseLenEff) begin
						state_d = selDisabled ? gwd_pkg::GWD_IDLE : gwd_pkg::GWD_RUN;
						pulseCnt_d = '0;
						msCnt_d = '0;
						divClear = 1'b1;
					end else begin
						pulseCnt_d = pulseCnt_q + `GWD_CNT_W'(1);
					end
				end
			end
			default: begin
				state_d = gwd_pkg::GWD_IDLE;
				msCnt_d = '0;
				pulseCnt_d = '0;
				divClear = 1'b1;
			end
		endcase
		sysReset_d = state_d == gwd_pkg::GWD_FIRE;
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= gwd_pkg::GWD_IDLE;
			msCnt_q <= '0;
			pulseCnt_q <= '0;
			sysReset_q <= 1'b0;
		end else begin
			state_q <= state_d;
			msCnt_q <= msCnt_d;
			pulseCnt_q <= pulseCnt_d;
			sysReset_q <= sysReset_d;
		end
	end

	// ----------------------------------------------------------------
	// Registers and interrupt
	// ----------------------------------------------------------------
	logic [`GWD_EVT_W-1:0] status_q;
	logic [`GWD_EVT_W-1:0] status_d;
	logic [`GWD_EVT_W-1:0] mask_q;
	logic [`GWD_EVT_W-1:0] mask_d;
	logic [`GWD_CNT_W-1:0] pulseLen_d;
	logic [`GWD_DATA_W-1:0] rdata_q;
	logic [`GWD_DATA_W-1:0] rdata_d;
	logic irq_q;
	logic irq_d;
	logic [`GWD_EVT_W-1:0] evtSet;
	logic [`GWD_EVT_W-1:0] evtClr;

	always_comb begin
		evtSet = '0;
		evtSet[`GWD_EVT_TIMEOUT] = evtTimeout;
		evtSet[`GWD_EVT_KICK] = kickEdge && (state_q == gwd_pkg::GWD_RUN);
		evtClr = '0;
		mask_d = mask_q;
		pulseLen_d = pulseLen_q;
		if (busReq.wr) begin
			if (gwd_hit(busReq.addr, `GWD_OFF_STATUS)) begin
				evtClr = busReq.wdata[`GWD_EVT_W-1:0];
			end else if (gwd_hit(busReq.addr, `GWD_OFF_MASK)) begin
				mask_d = busReq.wdata[`GWD_EVT_W-1:0];
			end else if (gwd_hit(busReq.addr, `GWD_OFF_PULSE)) begin
				pulseLen_d = busReq.wdata[`GWD_CNT_W-1:0];
			end
		end
		// Set beats clear in the same cycle so no event is lost
		status_d = (status_q & ~evtClr) | evtSet;
		irq_d = |(status_d & mask_d);
		rdata_d = '0;
		if (busReq.rd) begin
			if (gwd_hit(busReq.addr, `GWD_OFF_STATUS)) begin
				rdata_d[`GWD_EVT_W-1:0] = status_q;
			end else if (gwd_hit(busReq.addr, `GWD_OFF_MASK)) begin
				rdata_d[`GWD_EVT_W-1:0] = mask_q;
			end else if (gwd_hit(busReq.addr, `GWD_OFF_PULSE)) begin
				rdata_d[`GWD_CNT_W-1:0] = pulseLen_q;
			end else if (gwd_hit(busReq.addr, `GWD_OFF_SELECT)) begin
				rdata_d[`GWD_SELRD_SEL_LSB +: 3] = periodSelect;
				rdata_d[`GWD_SELRD_STATE_LSB +: 3] = state_q;
			end else if (gwd_hit(busReq.addr, `GWD_OFF_COUNT)) begin
				rdata_d[`GWD_CNT_W-1:0] = msCnt_q;
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			status_q <= `GWD_STATUS_RST;
			mask_q <= `GWD_MASK_RST;
			pulseLen_q <= `GWD_PULSE_RST;
			rdata_q <= '0;
			irq_q <= 1'b0;
		end else begin
			status_q <= status_d;
			mask_q <= mask_d;
			pulseLen_q <= pulseLen_d;
			rdata_q <= rdata_d;
			irq_q <= irq_d;
		end
	end

	assign busRdata = rdata_q;
	assign sysReset = sysReset_q;
	assign irq = irq_q;

endmodule : gwd_top

// >>> bench/gwd_top_sva.sv
// Checker of the watchdog reset output and read data against its pins; irq is not checked.
// Assumes the select pins change together.
`timescale 1ns/1ns
`include "gwd_map.svh"

module gwd_top_sva #(
	parameter int TICK_CYCLES = 4
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic hubGpioKickPin,
	input wire logic hubGpioSelHiPin,
	input wire logic hubGpioSelMidPin,
	input wire logic hubGpioSelLoPin,
	input wire gwd_pkg::gwd_bus_req_t busReq,
	input wire logic [`GWD_DATA_W-1:0] busRdata,
	input wire logic sysReset
);
	// ----
	// Quiet time
	// ----
	localparam int LO = TICK_CYCLES;
	localparam int HI = TICK_CYCLES + 8;
	logic [3:0] pins;
	logic [3:0] pinsQ;
	logic [31:0] quietD;
	logic [31:0] quietQ;
	logic [31:0] lim;
	always_comb begin
		pins = {hubGpioKickPin, hubGpioSelHiPin, hubGpioSelMidPin, hubGpioSelLoPin};
		// Pulse restarts the span, as does any pin change
		quietD = (sysReset || pins != pinsQ) ? 32'h0 : quietQ + 32'h1;
		case (pins[2:0])
			3'h0: lim = 32'h1;
			3'h1: lim = 32'hA;
			3'h2: lim = 32'h1E;
			3'h4: lim = 32'h64;
			3'h5: lim = 32'h3E8;
			3'h6: lim = 32'h2710;
			default: lim = 32'hEA60;
		endcase
		lim = lim * TICK_CYCLES;
	end
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pinsQ <= 4'h0;
			quietQ <= 32'h0;
		end else begin
			pinsQ <= pins;
			quietQ <= quietD;
		end
	end
	// ----
	// Properties
	// ----
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	expiry_bound_a: assert property (
		pinsQ == pins && pins[2:0] != 3'h3 && !sysReset |-> quietQ <= lim + 32'h8)
		else $error("reset missing after period");
	period_floor_a: assert property (
		$rose(sysReset) |-> quietQ + 32'h2 >= lim)
		else $error("reset before period");
	start_timing_a: assert property (
		$past(pins[2:0]) == 3'h3 && pins[2:0] == 3'h0 |-> ##[LO:HI] ($rose(sysReset) || pins != pinsQ))
		else $error("timing not started");
	disabled_quiet_a: assert property (
		(pins[2:0] == 3'h3) [*5] |=> !$rose(sysReset))
		else $error("reset while disabled");
	kick_restart_a: assert property (
		$changed(hubGpioKickPin) |-> ##5 !$rose(sysReset) ##1 !$rose(sysReset))
		else $error("kick did not restart");
	rdata_idle_a: assert property (
		!$past(busReq.rd) |-> busRdata == 32'h0)
		else $error("read data outside answer cycle");
endmodule : gwd_top_sva

bind gwd_top gwd_top_sva #(.TICK_CYCLES(TICK_CYCLES)) i_gwd_top_sva (
	.core_clk(core_clk), .resetn(resetn), .hubGpioKickPin(hubGpioKickPin),
	.hubGpioSelHiPin(hubGpioSelHiPin), .hubGpioSelMidPin(hubGpioSelMidPin),
	.hubGpioSelLoPin(hubGpioSelLoPin), .busReq(busReq), .busRdata(busRdata), .sysReset(sysReset)
);

// >>> bench/gwd_hub_model.sv
// Hub output lines under software control.
// Assumes requests arrive on core_clk edges.
`timescale 1ns/1ns

module gwd_hub_model (
	input wire logic core_clk,
	input wire logic [2:0] selCode,
	input wire logic kickReq,
	output logic kickPin,
	output logic [2:0] selPins
);
	initial begin
		kickPin = 1'b0;
		selPins = 3'h3;
	end
	always @(posedge core_clk) begin
		selPins <= selCode;
		if (kickReq) begin
			kickPin <= ~kickPin;
		end
	end
endmodule : gwd_hub_model

// >>> bench/gpio_selected_watchdog_test.sv
// Self-checking bench of the watchdog top.
// Assumes the hub model drives the pins.
`timescale 1ns/1ns

module gpio_selected_watchdog_test;
	// ----
	// Set-up
	// ----
	localparam int T = 4;
	logic core_clk;
	logic resetn = 1'b0;
	logic kickReq = 1'b0;
	logic [2:0] selCode = 3'h3;
	logic [2:0] selPins;
	logic kickPin, sysReset, irq;
	logic [31:0] busRdata, v;
	gwd_pkg::gwd_bus_req_t busReq = '0;
	int num_errors = 0;
	int total_checks = 0;
	int n;
	logic [2:0] rowSel [7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
	// Zero: too long to reach, must stay quiet
	int rowMs [7] = '{1, 10, 30, 100, 1000, 0, 0};
	gwd_hub_model i_gwd_hub_model (.core_clk(core_clk), .selCode(selCode), .kickReq(kickReq),
		.kickPin(kickPin), .selPins(selPins));
	gwd_top #(.TICK_CYCLES(T)) i_gwd_top (.core_clk(core_clk), .resetn(resetn),
		.hubGpioKickPin(kickPin), .hubGpioSelHiPin(selPins[2]), .hubGpioSelMidPin(selPins[1]),
		.hubGpioSelLoPin(selPins[0]), .busReq(busReq), .busRdata(busRdata), .sysReset(sysReset), .irq(irq));
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// ----
	// Tasks
	// ----
	task automatic chk(string name, logic [31:0] e, logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %s exp %h seen %h", name, e, s);
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge core_clk);
		busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		busReq <= '0;
	endtask : wr
	task automatic rd(logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		busReq <= '0;
		#1 d = busRdata;
	endtask : rd
	task automatic drive(logic [2:0] s);
		@(posedge core_clk);
		selCode <= s;
	endtask : drive
	task automatic kick();
		@(posedge core_clk);
		kickReq <= 1'b1;
		@(posedge core_clk);
		kickReq <= 1'b0;
	endtask : kick
	// Samples just after the edge so the registered output has settled
	task automatic waitHi(int lim);
		n = 0;
		while (sysReset !== 1'b1 && n < lim) begin
			@(posedge core_clk);
			#1;
			n++;
		end
	endtask : waitHi
	task automatic waitLo(int lim);
		n = 0;
		while (sysReset !== 1'b0 && n < lim) begin
			@(posedge core_clk);
			#1;
			n++;
		end
	endtask : waitLo
	task automatic final_report();
		if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : final_report
	// ----
	// Tests
	// ----
	initial begin
		repeat (4) @(posedge core_clk);
		resetn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			drive(rowSel[i]);
			waitHi(rowMs[i] == 0 ? 1100 * T : rowMs[i] * T + 20);
			if (rowMs[i] == 0) chk("quiet", 32'h0, {31'h0, sysReset});
			else chk("expiry", 32'h1, {31'h0, n >= rowMs[i] * T && n <= rowMs[i] * T + T + 6});
			drive(3'h3);
			repeat (8 * T) @(posedge core_clk);
			chk("disabled", 32'h0, {31'h0, sysReset});
		end
		drive(3'h1);
		for (int k = 0; k < 8; k++) begin
			repeat (5 * T) @(posedge core_clk);
			kick();
			chk("kickHolds", 32'h0, {31'h0, sysReset});
		end
		waitHi(10 * T + 20);
		chk("kickRestart", 32'h1, {31'h0, n >= 10 * T - 2 && n <= 11 * T + 6});
		drive(3'h3);
		repeat (8 * T) @(posedge core_clk);
		chk("irqMasked", 32'h0, {31'h0, irq});
		wr(8'h04, 32'h1);
		repeat (2) @(posedge core_clk);
		chk("irqRaised", 32'h1, {31'h0, irq});
		rd(8'h00, v);
		chk("statusTimeout", 32'h1, v & 32'h1);
		wr(8'h00, 32'h3);
		repeat (2) @(posedge core_clk);
		chk("irqCleared", 32'h0, {31'h0, irq});
		rd(8'h00, v);
		chk("statusClear", 32'h0, v);
		rd(8'h20, v);
		chk("unmapped", 32'h0, v);
		// Longer reset pulse: two ticks
		wr(8'h08, 32'h2);
		rd(8'h08, v);
		chk("pulseLen", 32'h2, v);
		drive(3'h0);
		waitHi(T + 20);
		chk("pulseExpiry", 32'h1, {31'h0, n >= T && n <= 2 * T + 6});
		chk("irqTimeout", 32'h1, {31'h0, irq});
		waitLo(4 * T);
		chk("pulseWidth", 32'h1, {31'h0, n >= 2 * T && n <= 2 * T + 2});
		drive(3'h3);
		repeat (8 * T) @(posedge core_clk);
		drive(3'h0);
		repeat (T) @(posedge core_clk);
		drive(3'h3);
		resetn <= 1'b0;
		repeat (4) @(posedge core_clk);
		chk("rstOut", 32'h0, {30'h0, sysReset, irq});
		resetn <= 1'b1;
		repeat (4) @(posedge core_clk);
		rd(8'h0C, v);
		chk("selIdle", 32'h13, v);
		rd(8'h10, v);
		chk("countIdle", 32'h0, v);
		final_report();
	end
	initial begin
		// About twice the expected run of some 14000 cycles
		#1200000;
		num_errors++;
		final_report();
	end
endmodule : gpio_selected_watchdog_test
